// [core/phyx_pkg.sv]
// Package for the extended control and status register slice.
// Assumes one 100 MHz clock shared with the management frame engine.
package phyx_pkg;

    localparam int unsigned REG_ADDR_W = 5;
    localparam int unsigned REG_DATA_W = 16;
    localparam int unsigned PAGE_CODE_W = 4;
    localparam int unsigned PROG_W = 3;

    // Register numbers on the management bus.
    localparam logic [4:0] ADDR_PARTNER_PAGE = 5'h08;
    localparam logic [4:0] ADDR_RSVD_FIRST   = 5'h09;
    localparam logic [4:0] ADDR_RSVD_LAST    = 5'h0F;
    localparam logic [4:0] ADDR_EXT_CTRL     = 5'h10;
    localparam logic [4:0] ADDR_QUICK_POLL   = 5'h11;

    // Extended control field positions.
    localparam int unsigned CTL_CIPHER_DIS = 0;
    localparam int unsigned CTL_TX_INVALID = 2;
    localparam int unsigned CTL_NRZI       = 3;
    localparam int unsigned CTL_CIPHER_TST = 5;

    // Writable bits of extended control; all others store zero.
    localparam logic [15:0] CTL_WR_MASK = 16'h002D;
    localparam logic [15:0] CTL_RESET   = 16'h0008;

    // Quick poll status field positions.
    localparam int unsigned QP_DUPLEX  = 14;
    localparam int unsigned QP_PROG_LO = 11;

    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [2:0]  PROG_RESET = 3'h0;
    localparam logic [3:0]  PAGE_RESET = 4'h0;
    localparam logic        DUPLEX_RESET = 1'h0;

    // One management access, already deframed from the serial bus.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } phyx_req_t;

    // Read answer to the frame engine.
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } phyx_rsp_t;

endpackage

// [core/phyx_regs.sv]
// Extended control and quick poll status registers with partner page code bits.
// Assumes the management frame engine hands over one deframed access per pulse,
// and that status inputs are synchronous to sys_clk.
// Behaviour
// - Partner page bits above the code bits, read-only, zero.
// - Page code bits copied verbatim from partner page.
// - Registers nine to fifteen reserved, no function.
// - Invalid code transmit only when its bit set.
// - Scrambler active unless cipher-disable bit set.
// - Duplex status read-only, one means full.
// - Progress code top bit latched, reset zero.
// - Progress code middle bit latched, reset zero.
// - Progress bits form one jointly decoded code.
// - Quick poll register upper bits are read-only.
// - Progress code low bit latched, reset zero.
`timescale 1ns/1ps

module phyx_regs
    import phyx_pkg::*;
#(
    parameter int unsigned DATA_W = REG_DATA_W
)
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Management access port
    input  wire phyx_req_t              mgmtReq,
    output phyx_rsp_t                   mgmtRsp,
    // Link partner next page
    input  wire logic                   pageRxStrobe,
    input  wire logic [PAGE_CODE_W-1:0] pageRxCode,
    // Negotiation state
    input  wire logic                   duplexFull,
    input  wire logic [PROG_W-1:0]      progressCode,
    // Transmit path controls
    output logic                        txInvalidCodes,
    output logic                        cipherBypass,
    output logic                        nrziEncode,
    output logic                        cipherTestMode
);

    // Only 16-bit management words are served.
    if (DATA_W != REG_DATA_W)
    begin : g_bad_width
        $error("phyx_regs supports only 16-bit management data");
    end

    // The duplex bit and the progress code must fit the quick poll word without overlap.
    if ((QP_PROG_LO + PROG_W > QP_DUPLEX) || (PAGE_CODE_W > DATA_W))
    begin : g_bad_layout
        $error("phyx_regs quick poll or page fields do not fit the word");
    end

    logic [PAGE_CODE_W-1:0] pageCode_q;
    logic [DATA_W-1:0]      ctl_q;
    logic [PROG_W-1:0]      progLatch_q;
    logic [PROG_W-1:0]      progLatch_d;
    logic                   duplex_q;
    logic                   rspValid_q;
    logic [DATA_W-1:0]      rspData_q;
    logic [DATA_W-1:0]      pageWord;
    logic [DATA_W-1:0]      pollWord;
    logic [DATA_W-1:0]      rdWord;
    logic                   pageSel;
    logic                   ctlSel;
    logic                   pollSel;
    logic                   rsvdSel;
    logic                   ctlWrite;
    logic                   pollRead;

    // Address decode of the current management access.
    assign pageSel  = (mgmtReq.addr == ADDR_PARTNER_PAGE);
    assign ctlSel   = (mgmtReq.addr == ADDR_EXT_CTRL);
    assign pollSel  = (mgmtReq.addr == ADDR_QUICK_POLL);
    assign rsvdSel  = (mgmtReq.addr >= ADDR_RSVD_FIRST) && (mgmtReq.addr <= ADDR_RSVD_LAST);
    assign ctlWrite = mgmtReq.wr && ctlSel;
    assign pollRead = mgmtReq.rd && pollSel;

    // Page code follows the received page exactly, with no interpretation.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pageCode_q <= PAGE_RESET;
        end
        else if (pageRxStrobe)
        begin
            pageCode_q <= pageRxCode;
        end
    end

    // Only the documented option bits store; reserved bits always hold zero.
    // Writes to any other address are dropped without effect.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= CTL_RESET;
        end
        else if (ctlWrite)
        begin
            ctl_q <= mgmtReq.wdata & CTL_WR_MASK;
        end
    end

    assign txInvalidCodes = ctl_q[CTL_TX_INVALID];
    assign cipherBypass   = ctl_q[CTL_CIPHER_DIS];
    assign nrziEncode     = ctl_q[CTL_NRZI];
    assign cipherTestMode = ctl_q[CTL_CIPHER_TST];

    // The progress code keeps the highest value seen since the last poll read.
    // A read restarts from the live code, so progress made during the read stays.
    always_comb
    begin
        if (pollRead)
        begin
            progLatch_d = progressCode;
        end
        else if (progressCode > progLatch_q)
        begin
            progLatch_d = progressCode;
        end
        else
        begin
            progLatch_d = progLatch_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            progLatch_q <= PROG_RESET;
        end
        else
        begin
            progLatch_q <= progLatch_d;
        end
    end

    // Duplex follows the resolved mode with one cycle of lag.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            duplex_q <= DUPLEX_RESET;
        end
        else
        begin
            duplex_q <= duplexFull;
        end
    end

    // Partner page word: only the low code bits live here, the rest read zero.
    always_comb
    begin
        pageWord                  = ZERO_WORD;
        pageWord[PAGE_CODE_W-1:0] = pageCode_q;
    end

    // Quick poll word: duplex and the latched progress code; other bits read zero.
    always_comb
    begin
        pollWord                       = ZERO_WORD;
        pollWord[QP_DUPLEX]            = duplex_q;
        pollWord[QP_PROG_LO +: PROG_W] = progLatch_q;
    end

    // Read multiplexer; quick poll has no write path at all.
    always_comb
    begin
        rdWord = ZERO_WORD;
        if (pageSel)
        begin
            rdWord = pageWord;
        end
        else if (ctlSel)
        begin
            rdWord = ctl_q;
        end
        else if (pollSel)
        begin
            rdWord = pollWord;
        end
        else if (rsvdSel)
        begin
            rdWord = ZERO_WORD;
        end
    end

    // The answer strobe lasts one cycle after each read.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspValid_q <= 1'h0;
        end
        else
        begin
            rspValid_q <= mgmtReq.rd;
        end
    end

    // Read data stays put until the next read answer replaces it.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspData_q <= ZERO_WORD;
        end
        else if (mgmtReq.rd)
        begin
            rspData_q <= rdWord;
        end
    end

    // Both response fields come straight from flip-flops.
    assign mgmtRsp = '{valid: rspValid_q, data: rspData_q};

endmodule // phyx_regs

// [test/phyx_regs_monitor.sv]
// Checker on the ports of phyx_regs.
// Assumes one clock domain.
`timescale 1ns/1ps
module phyx_regs_monitor
    import phyx_pkg::*;
(
    // Watched ports
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire phyx_req_t  mgmtReq,
    input wire phyx_rsp_t  mgmtRsp,
    input wire logic       pageRxStrobe,
    input wire logic [3:0] pageRxCode,
    input wire logic       duplexFull,
    input wire logic [2:0] progressCode,
    input wire logic       txInvalidCodes,
    input wire logic       cipherBypass
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire rdQp = mgmtReq.rd && mgmtReq.addr == ADDR_QUICK_POLL;
    wire rdPg = mgmtReq.rd && mgmtReq.addr == ADDR_PARTNER_PAGE;
    wire wrCtl = mgmtReq.wr && mgmtReq.addr == ADDR_EXT_CTRL;
    a_read_answer:
        assert property (mgmtReq.rd |=> mgmtRsp.valid) else $error("no answer");
    a_rsvd_zero:
        assert property (mgmtReq.rd && mgmtReq.addr inside {[5'h09:5'h0F]}
            |=> mgmtRsp.data == ZERO_WORD) else $error("reserved read");
    a_page_code:
        assert property (pageRxStrobe ##1 !pageRxStrobe ##1 rdPg && !pageRxStrobe
            |=> mgmtRsp.data[3:0] == $past(pageRxCode, 3)) else $error("page code");
    a_duplex_bit:
        assert property (rdQp |=> mgmtRsp.data[QP_DUPLEX] == $past(duplexFull, 2))
        else $error("duplex");
    a_prog_max:
        assert property (rdQp |=> mgmtRsp.data[13:11] >= $past(progressCode, 2))
        else $error("progress");
    a_ctl_write:
        assert property (wrCtl |=> {txInvalidCodes, cipherBypass}
            == $past({mgmtReq.wdata[2], mgmtReq.wdata[0]})) else $error("ctl write");
    a_ctl_hold:
        assert property (!wrCtl |=> $stable({txInvalidCodes, cipherBypass}))
        else $error("ctl hold");
    a_ctl_reset:
        assert property (disable iff (1'h0) !rst_n ##1 !rst_n
            |-> !txInvalidCodes && !cipherBypass) else $error("ctl reset");
    c_qp: cover property (rdQp);
    c_wr: cover property (wrCtl);
    c_pg: cover property (pageRxStrobe ##2 rdPg);
endmodule // phyx_regs_monitor
bind phyx_regs phyx_regs_monitor phyx_regs_monitor_inst (.*);

// [test/phyx_mgmt_model.sv]
// Management controller model issuing one deframed access per call.
// Assumes requests launch on the falling edge of sys_clk.
`timescale 1ns/1ps
module phyx_mgmt_model
    import phyx_pkg::*;
(
    // Register port
    input wire logic      sys_clk,
    output phyx_req_t     mgmtReq,
    input wire phyx_rsp_t mgmtRsp
);
    // Reserved bits of extended control, which the controller always writes as zero.
    localparam logic [15:0] RSVD_BITS = 16'h7812;
    initial mgmtReq = '0;
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output phyx_rsp_t r);
        @(negedge sys_clk);
        mgmtReq = '{!w, w, a, a == ADDR_EXT_CTRL ? d & ~RSVD_BITS : d};
        @(negedge sys_clk);
        r = mgmtRsp;
        mgmtReq = '0;
    endtask
endmodule // phyx_mgmt_model

// [test/tb.sv]
// Self-checking bench for phyx_regs.
// Assumes inputs change on the falling edge of sys_clk.
`timescale 1ns/1ps
module tb
    import phyx_pkg::*;
;
    typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [3:0] c;} phyx_row_t;
    logic       sys_clk = 0;
    logic       rst_n = 0;
    logic       pageRxStrobe = 0;
    logic       duplexFull = 0;
    logic [3:0] pageRxCode = '0;
    logic [2:0] progressCode = '0;
    logic       txInvalidCodes, cipherBypass, nrziEncode, cipherTestMode;
    phyx_req_t  mgmtReq;
    phyx_rsp_t  mgmtRsp, r;
    int         mismatches = 0, checkCount = 0;
    wire [3:0]  ctl = {cipherTestMode, nrziEncode, txInvalidCodes, cipherBypass};
    // Writes carry data, reads the expected word; the last field is the expected option outputs.
    phyx_row_t  rows[12] = '{'{1'h0, 5'h10, 16'h0008, 4'h4}, '{1'h1, 5'h10, 16'h07ED, 4'hF},
        '{1'h0, 5'h10, 16'h002D, 4'hF}, '{1'h1, 5'h10, 16'h0005, 4'h3},
        '{1'h1, 5'h09, 16'hFFFF, 4'h3}, '{1'h1, 5'h11, 16'hFFFF, 4'h3},
        '{1'h1, 5'h08, 16'hFFFF, 4'h3}, '{1'h0, 5'h09, 16'h0000, 4'h3},
        '{1'h0, 5'h0F, 16'h0000, 4'h3}, '{1'h0, 5'h11, 16'h0000, 4'h3},
        '{1'h0, 5'h08, 16'h0000, 4'h3}, '{1'h0, 5'h12, 16'h0000, 4'h3}};
    phyx_regs phyx_regs_inst (.sys_clk, .rst_n, .mgmtReq, .mgmtRsp, .pageRxStrobe,
        .pageRxCode, .duplexFull, .progressCode, .txInvalidCodes, .cipherBypass,
        .nrziEncode, .cipherTestMode);
    phyx_mgmt_model mdl (.sys_clk, .mgmtReq, .mgmtRsp);
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic endSim;
        $display("checks=%0d mismatches=%0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #5 sys_clk = ~sys_clk;
    initial
    begin
        repeat (20) @(negedge sys_clk);
        chk(ctl, 4'h4);
        rst_n = 1;
        foreach (rows[i])
        begin
            mdl.xfer(rows[i].w, rows[i].a, rows[i].d, r);
            chk(ctl, rows[i].c);
            if (!rows[i].w) chk({r.valid, r.data}, {1'h1, rows[i].d});
        end
        chk(ctl, 4'h3);
        pageRxCode = 4'hA;
        pageRxStrobe = 1;
        @(negedge sys_clk);
        pageRxStrobe = 0;
        duplexFull = 1;
        progressCode = 3'h5;
        mdl.xfer(0, ADDR_PARTNER_PAGE, 0, r);
        chk(r.data[3:0], 4'hA);
        progressCode = 3'h2;
        mdl.xfer(0, ADDR_QUICK_POLL, 0, r);
        chk(r.data[14:11], 4'hD);
        mdl.xfer(0, ADDR_QUICK_POLL, 0, r);
        chk(r.data[14:11], 4'hA);
        rst_n = 0;
        repeat (2) @(negedge sys_clk);
        chk(ctl, 4'h4);
        rst_n = 1;
        mdl.xfer(0, ADDR_EXT_CTRL, 0, r);
        chk({r.valid, r.data}, {1'h1, CTL_RESET});
        mdl.xfer(0, ADDR_PARTNER_PAGE, 0, r);
        chk({r.valid, r.data}, {1'h1, 16'h0000});
        endSim();
    end
endmodule // tb
